/* File: hdl/adsd_ctrl.sv */
// Acquisition controller: scan, decimate, filter, ping-pong store
// ---------------------------------------------------------------
// How it works
// - Channel count must be 1 to 64; init rejects anything else.
// - Each buffer holds channel count times samples-per-buffer words.
// - Base conversion rate of 138 kHz is shared across scan slots.
// - One output kept per channel every decimation count plus one scans.
// - Skipped samples averaged by two-term filter, weights 0.0 to 1.0.
// - Feedback 0 with input weight 1 stores raw value unchanged.
// - Mux follows channel-order table; new selection before each conversion.
// - After init the block stays idle until a start command.
// - Acquisition runs until a stop or init command halts it.
// - Full buffer raises ready, storage continues in the other one.
// - Nonzero ready names the full buffer; fetch must pass it back.
// - Ready is 0 for none, 1 or 2 for first or second buffer.
// - Fetching the ready buffer clears ready to zero.
// - Init leaves ready cleared; an explicit clear command exists too.
// - Stored results are 16-bit two's-complement values.
// - Buffer words interleaved: kept scan times channels plus position.
// - Init reports 1 for success, 0 for failure.
// ---------------------------------------------------------------
`timescale 1ns/100ps
module adsd_ctrl
  import adsd_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [10:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Converter and multiplexer
  output logic      [5:0]  mux_sel,
  output logic             conv_start,
  input  wire logic [15:0] conv_data,
  input  wire logic        conv_valid
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  adsd_cfg_t          cfg;
  adsd_state_t        state;
  adsd_state_t        next_state;
  logic        [5:0]  scan_tab [MAX_CHAN];
  logic signed [15:0] y_mem [MAX_CHAN];
  logic        [15:0] buf_mem [2][BUF_WORDS];
  logic               done;
  logic               wr_acc;
  logic        [31:0] rd_mux;
  logic        [31:0] cfg_img;
  logic        [31:0] dec_img;
  logic        [31:0] coef_img;
  logic               be0;
  logic               ctrl_wr;
  logic               init_cmd;
  logic               start_cmd;
  logic               stop_cmd;
  logic               clr_cmd;
  logic               fetch_wr;
  logic               fetch_hit;
  logic        [1:0]  fid;
  logic               cfg_ok;
  logic        [15:0] buf_len;
  logic               init_ok;
  logic               running;
  logic               restart;
  logic               fetch_ok;
  logic               rd_sel;
  logic        [10:0] div_cnt;
  logic               tick;
  logic               conv_go;
  logic               samp;
  logic        [5:0]  pos;
  logic        [5:0]  next_pos;
  logic               last_slot;
  logic        [15:0] dec_cnt;
  logic               keep;
  logic               store;
  logic               fill;
  logic        [7:0]  wr_ptr;
  logic               act;
  logic        [1:0]  ready;
  logic signed [15:0] filt_y;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Bus slave: one wait cycle, then the answer
  // ---------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~done;
  assign wr_acc = avs_write & done;
  assign be0 = avs_byteenable[0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= (avs_read | avs_write) & ~done;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    if (avs_address[10]) begin
      rd_mux = {16'h0, buf_mem[rd_sel][avs_address[9:2]]};
    end else if (avs_address[10:8] == SCAN_WIN) begin
      rd_mux = {26'h0, scan_tab[avs_address[7:2]]};
    end else begin
      case ({avs_address[10:2], 2'b00})
        CFG_OFS:   rd_mux = {15'h0, cfg.nsamp, 1'b0, cfg.nch};
        DEC_OFS:   rd_mux = {16'h0, cfg.ncount};
        COEF_OFS:  rd_mux = {cfg.scale, cfg.coeff};
        STAT_OFS:  rd_mux = {25'h0, fetch_ok, running, init_ok,
                             2'b00, ready};
        FETCH_OFS: rd_mux = {30'h0, rd_sel ? RDY_BUF2 : RDY_BUF1};
        default:   rd_mux = 32'h0;
      endcase
    end
  end

  // Read data is loaded in the wait cycle and stands in the answer cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read & ~done) begin
      avs_readdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Configuration, locked while running so a scan never changes shape
  // ---------------------------------------------------------------
  assign cfg_img  = be_merge({15'h0, cfg.nsamp, 1'b0, cfg.nch},
                             avs_writedata, avs_byteenable);
  assign dec_img  = be_merge({16'h0, cfg.ncount}, avs_writedata,
                             avs_byteenable);
  assign coef_img = be_merge({cfg.scale, cfg.coeff}, avs_writedata,
                             avs_byteenable);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '{RST_NCH, RST_NSAMP, RST_NCOUNT, RST_COEF, RST_SCALE};
    end else if (wr_acc && !running) begin
      case ({avs_address[10:2], 2'b00})
        CFG_OFS: begin
          cfg.nch   <= cfg_img[CFG_NCH_LSB +: 7];
          cfg.nsamp <= cfg_img[CFG_NSAMP_LSB +: 9];
        end
        DEC_OFS:  cfg.ncount <= dec_img[15:0];
        COEF_OFS: begin
          cfg.coeff <= coef_img[15:0];
          cfg.scale <= coef_img[COEF_SCL_LSB +: 16];
        end
        default: ;
      endcase
    end
  end

  // No reset: the table is loaded by software before any start
  always_ff @(posedge ref_clk) begin
    if (wr_acc && !running && be0 && avs_address[10:8] == SCAN_WIN) begin
      scan_tab[avs_address[7:2]] <= avs_writedata[5:0];
    end
  end

  // ---------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------
  assign ctrl_wr   = wr_acc && be0 && {avs_address[10:2], 2'b00} == CTRL_OFS;
  assign init_cmd  = ctrl_wr & avs_writedata[CTRL_INIT];
  assign start_cmd = ctrl_wr & avs_writedata[CTRL_START];
  assign stop_cmd  = ctrl_wr & avs_writedata[CTRL_STOP];
  assign clr_cmd   = ctrl_wr & avs_writedata[CTRL_CLR];
  assign fetch_wr  = wr_acc && be0
                     && {avs_address[10:2], 2'b00} == FETCH_OFS;
  assign fid       = avs_writedata[1:0];
  assign fetch_hit = fetch_wr && fid != RDY_NONE && fid == ready;

  assign buf_len = {9'h000, cfg.nch} * {7'h00, cfg.nsamp};
  assign cfg_ok  = cfg.nch != 7'h00 && cfg.nch <= 7'(MAX_CHAN)
                   && cfg.nsamp != 9'h000
                   && buf_len <= 16'(BUF_WORDS)
                   && cfg.coeff <= Q_ONE && cfg.scale <= Q_ONE;
  assign restart = init_cmd | (start_cmd & init_ok);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_ok <= 1'b0;
      running <= 1'b0;
    end else if (init_cmd) begin
      init_ok <= cfg_ok;
      running <= 1'b0;
    end else if (start_cmd && init_ok) begin
      running <= 1'b1;
    end else if (stop_cmd) begin
      running <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ok <= 1'b0;
      rd_sel   <= 1'b0;
    end else if (fetch_wr) begin
      fetch_ok <= fetch_hit;
      if (fid == RDY_BUF1 || fid == RDY_BUF2) begin
        rd_sel <= (fid == RDY_BUF2);
      end
    end
  end

  // ---------------------------------------------------------------
  // Conversion pacing and sequencing
  // ---------------------------------------------------------------
  assign tick = running && div_cnt == 11'h000;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= CONV_DIV;
    end else if (!running || restart || tick) begin
      div_cnt <= CONV_DIV;
    end else begin
      div_cnt <= div_cnt - 11'h001;
    end
  end

  always_comb begin
    next_state = state;
    conv_go    = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (running) next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (tick) begin
          next_state = ST_CONV;
          conv_go    = 1'b1;
        end
      end
      ST_CONV: begin
        if (conv_valid) next_state = ST_WAIT;
      end
      default: next_state = ST_IDLE;
    endcase
    if (!running || restart) begin
      next_state = ST_IDLE;
      conv_go    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      conv_start <= 1'b0;
    end else begin
      state      <= next_state;
      conv_start <= conv_go;
    end
  end

  // A result arriving after stop or restart is dropped
  assign samp      = state == ST_CONV && conv_valid && running && !restart;
  assign last_slot = {1'b0, pos} == cfg.nch - 7'h01;
  assign next_pos  = last_slot ? 6'h00 : pos + 6'h01;
  assign keep      = dec_cnt == cfg.ncount;
  assign store     = samp & keep;
  assign fill      = store && {8'h00, wr_ptr} == buf_len - 16'h0001;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos     <= 6'h00;
      dec_cnt <= 16'h0000;
      mux_sel <= 6'h00;
    end else if (restart) begin
      pos     <= 6'h00;
      dec_cnt <= 16'h0000;
      mux_sel <= scan_tab[0];
    end else if (samp) begin
      pos     <= next_pos;
      mux_sel <= scan_tab[next_pos];
      if (last_slot) begin
        dec_cnt <= keep ? 16'h0000 : dec_cnt + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Filter state and ping-pong storage
  // ---------------------------------------------------------------
  adsd_filter u_filter (
    .x     ($signed(conv_data)),
    .y_old (y_mem[pos]),
    .coeff (cfg.coeff),
    .scale (cfg.scale),
    .y_new (filt_y)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MAX_CHAN; i++) y_mem[i] <= 16'h0000;
    end else if (restart) begin
      for (int i = 0; i < MAX_CHAN; i++) y_mem[i] <= 16'h0000;
    end else if (samp) begin
      y_mem[pos] <= filt_y;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (store) begin
      buf_mem[act][wr_ptr] <= filt_y;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 8'h00;
      act    <= 1'b0;
    end else if (restart) begin
      wr_ptr <= 8'h00;
      act    <= 1'b0;
    end else if (fill) begin
      wr_ptr <= 8'h00;
      act    <= ~act;
    end else if (store) begin
      wr_ptr <= wr_ptr + 8'h01;
    end
  end

  // A fill in the same cycle as a clear wins, so no buffer is lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= RDY_NONE;
    end else if (fill) begin
      ready <= act ? RDY_BUF2 : RDY_BUF1;
    end else if (fetch_hit || clr_cmd || init_cmd) begin
      ready <= RDY_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [11:0] gap;
  logic [15:0] n_store;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap     <= 12'hfff;
      n_store <= 16'h0000;
    end else begin
      if (conv_start) gap <= 12'h000;
      else if (gap != 12'hfff) gap <= gap + 12'h001;
      if (restart || fill) n_store <= 16'h0000;
      else if (store) n_store <= n_store + 16'h0001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence fill_s;
    fill && !restart;
  endsequence

  sequence fetch_s;
    fetch_hit && !fill;
  endsequence

  nch_range_a: assert property (
    running |-> cfg.nch != 7'h00 && cfg.nch <= 7'(MAX_CHAN))
    else $error("scan running with illegal channel count");
  buf_len_a: assert property (
    fill_s |-> n_store == buf_len - 16'h0001)
    else $error("buffer filled at wrong length");
  conv_gap_a: assert property (
    conv_start |-> {1'b0, gap} >= {1'b0, CONV_DIV})
    else $error("conversions started too close together");
  decim_a: assert property (
    samp && last_slot && keep |=> dec_cnt == 16'h0000)
    else $error("decimation count not restarted");
  filt_avg_a: assert property (
    samp && {1'b0, cfg.coeff} + {1'b0, cfg.scale} == {1'b0, Q_ONE}
    && $signed(conv_data) == y_mem[pos] |-> filt_y == $signed(conv_data))
    else $error("filter does not hold a steady input");
  filt_pass_a: assert property (
    samp && cfg.coeff == 16'h0000 && cfg.scale == Q_ONE
    |-> filt_y == $signed(conv_data))
    else $error("transparent filter altered the sample");
  mux_step_a: assert property (
    samp ##1 !restart |-> mux_sel == scan_tab[pos])
    else $error("mux not set to next table entry");
  idle_a: assert property (
    !running |=> !conv_start [*2])
    else $error("conversion started while idle");
  pingpong_a: assert property (
    fill_s |=> act != $past(act)
    && ready == ($past(act) ? RDY_BUF2 : RDY_BUF1))
    else $error("buffer swap or ready code wrong");
  fetch_clr_a: assert property (
    fetch_s |=> ready == RDY_NONE)
    else $error("fetch did not clear ready");
  init_res_a: assert property (
    init_cmd |=> init_ok == $past(cfg_ok) && !running)
    else $error("init result wrong");

endmodule

/* File: hdl/adsd_filter.sv */
// Two-term recursive averaging filter, Q1.15 weights
`timescale 1ns/100ps
module adsd_filter
  import adsd_pkg::*;
(
  // Sample in, state in
  input  wire logic signed [15:0] x,
  input  wire logic signed [15:0] y_old,
  // Weights, Q1.15 unsigned
  input  wire logic        [15:0] coeff,
  input  wire logic        [15:0] scale,
  // Filtered result
  output logic signed      [15:0] y_new
);

  logic signed [33:0] px;
  logic signed [33:0] py;
  logic signed [33:0] acc;
  logic signed [18:0] q;
  logic               ovf;

  // Saturate rather than wrap when weights sum above one
  always_comb begin
    px    = x * $signed({1'b0, scale});
    py    = y_old * $signed({1'b0, coeff});
    acc   = px + py;
    q     = acc[33:15];
    ovf   = (q[18:15] != {4{q[15]}});
    y_new = ovf ? (q[18] ? 16'h8000 : 16'h7fff) : q[15:0];
  end

endmodule

/* File: hdl/adsd_pkg.sv */
// Constants and types shared by the acquisition controller files
package adsd_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ       = 250_000_000;
  localparam int CONV_RATE_HZ = 138_000;
  localparam logic [10:0] CONV_DIV = 11'(CLK_HZ / CONV_RATE_HZ - 1);

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int MAX_CHAN  = 64;
  localparam int BUF_WORDS = 256;
  localparam logic [15:0] Q_ONE = 16'h8000;

  // ---------------------------------------------------------------
  // Register byte offsets and windows
  // ---------------------------------------------------------------
  localparam logic [10:0] CTRL_OFS  = 11'h000;
  localparam logic [10:0] CFG_OFS   = 11'h004;
  localparam logic [10:0] DEC_OFS   = 11'h008;
  localparam logic [10:0] COEF_OFS  = 11'h00c;
  localparam logic [10:0] STAT_OFS  = 11'h010;
  localparam logic [10:0] FETCH_OFS = 11'h014;
  localparam logic [2:0]  SCAN_WIN  = 3'h1;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_INIT     = 0;
  localparam int CTRL_START    = 1;
  localparam int CTRL_STOP     = 2;
  localparam int CTRL_CLR      = 3;
  localparam int CFG_NCH_LSB   = 0;
  localparam int CFG_NSAMP_LSB = 8;
  localparam int COEF_SCL_LSB  = 16;

  // ---------------------------------------------------------------
  // Reset values and ready codes
  // ---------------------------------------------------------------
  localparam logic [6:0]  RST_NCH    = 7'h01;
  localparam logic [8:0]  RST_NSAMP  = 9'h001;
  localparam logic [15:0] RST_NCOUNT = 16'h0000;
  localparam logic [15:0] RST_COEF   = 16'h0000;
  localparam logic [15:0] RST_SCALE  = 16'h8000;
  localparam logic [1:0]  RDY_NONE   = 2'h0;
  localparam logic [1:0]  RDY_BUF1   = 2'h1;
  localparam logic [1:0]  RDY_BUF2   = 2'h2;

  typedef struct packed {
    logic [6:0]  nch;
    logic [8:0]  nsamp;
    logic [15:0] ncount;
    logic [15:0] coeff;
    logic [15:0] scale;
  } adsd_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } adsd_state_t;

endpackage

/* File: tb/adsd_conv_model.sv */
// Converter model: answers each start pulse with a numbered sample
`timescale 1ns/100ps
module adsd_conv_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Bench control
  input  wire logic        seq_clr,
  input  wire logic        slow,
  input  wire logic [15:0] base,
  // Converter side
  input  wire logic [5:0]  mux_sel,
  input  wire logic        conv_start,
  output logic      [15:0] conv_data,
  output logic             conv_valid,
  // Observation
  output int               n_conv,
  output int               min_gap,
  output int               max_gap
);
  int         wait_c;
  int         gap;
  int         seq;
  logic       busy;
  logic [5:0] ch;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      conv_valid <= 1'b0;
      conv_data <= 16'h5a5a;
      n_conv <= 0;
      gap <= 0;
      min_gap <= 0;
      max_gap <= 0;
    end else begin
      conv_valid <= 1'b0;
      // Idle bus keeps moving so a stale sample is never mistaken
      conv_data <= ~conv_data;
      gap <= gap + 1;
      if (seq_clr) begin
        n_conv <= 0;
        min_gap <= 0;
        max_gap <= 0;
      end else if (conv_start) begin
        busy <= 1'b1;
        ch <= mux_sel;
        seq <= n_conv;
        n_conv <= n_conv + 1;
        wait_c <= slow ? 1500 : 3;
        gap <= 1;
        if (n_conv > 0 && (min_gap == 0 || gap < min_gap))
          min_gap <= gap;
        if (n_conv > 0 && gap > max_gap)
          max_gap <= gap;
      end else if (busy) begin
        wait_c <= wait_c - 1;
        if (wait_c == 1) begin
          busy <= 1'b0;
          conv_valid <= 1'b1;
          conv_data <= base + 16'(seq * 256) + {10'h0, ch};
        end
      end
    end
  end
endmodule

/* File: tb/adsd_ctrl_tb_top.sv */
// Self-checking bench for the acquisition controller
`timescale 1ns/100ps
module adsd_ctrl_tb_top;
  import adsd_pkg::*;
  typedef struct packed {logic [31:0] cfg; logic ok;} adsd_row_t;
  logic        ref_clk, rst_n, avs_read, avs_write, conv_start, conv_valid;
  logic        seq_clr, slow, avs_waitrequest;
  logic [10:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [5:0]  mux_sel;
  logic [15:0] conv_data, base;
  logic [5:0]  tbl [2];
  int          n_conv, min_gap, max_gap, n_fail, checked, cyc, n0, y;
  adsd_row_t   rows [7];

  // ---------------------------------------------------------------
  // Clock, instances, timeout
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  adsd_ctrl DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mux_sel(mux_sel),
    .conv_start(conv_start), .conv_data(conv_data),
    .conv_valid(conv_valid));

  adsd_conv_model conv (.ref_clk(ref_clk), .rst_n(rst_n),
    .seq_clr(seq_clr), .slow(slow), .base(base), .mux_sel(mux_sel),
    .conv_start(conv_start), .conv_data(conv_data),
    .conv_valid(conv_valid), .n_conv(n_conv), .min_gap(min_gap),
    .max_gap(max_gap));

  // Ceiling sits well above the roughly 40k cycles the tests need
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 70000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("Counts: checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask

  // Request held until the edge that sees waitrequest low, released there
  task automatic bus(input logic wr, input logic [10:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge ref_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [10:0] a, input logic [31:0] m,
                     input logic [31:0] e, input string w);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(w, e, q & m);
  endtask

  task automatic wait_rdy;
    logic [31:0] q;
    q = 32'h0;
    while (q[1:0] == 2'h0)
      bus(1'b0, STAT_OFS, 32'h0, q);
  endtask

  task automatic restart;
    wr(CTRL_OFS, 32'h1);
    @(posedge ref_clk);
    seq_clr <= 1'b1;
    @(posedge ref_clk);
    seq_clr <= 1'b0;
    wr(CTRL_OFS, 32'h2);
  endtask

  task automatic bufchk(input int s0);
    logic [15:0] e;
    for (int w = 0; w < 4; w++) begin
      e = base + 16'((s0 + w) * 256) + {10'h0, tbl[w % 2]};
      rdc(11'(11'h400 + 4 * w), 32'hffffffff, {16'h0, e}, "word");
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rows = '{'{32'h0100, 1'b0}, '{32'h0141, 1'b0}, '{32'h0440, 1'b1},
             '{32'h0540, 1'b0}, '{32'h0001, 1'b0}, '{32'h10001, 1'b1},
             '{32'h0202, 1'b1}};
    tbl = '{6'h2a, 6'h05};
    {rst_n, avs_read, avs_write, seq_clr, slow} = 5'h0;
    avs_address = 11'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    base = 16'hf000;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(STAT_OFS, 32'hffffffff, 32'h0, "stat reset");
    rdc(11'h020, 32'hffffffff, 32'h0, "unmapped");
    rdc(CTRL_OFS, 32'hffffffff, 32'h0, "ctrl read");
    wr(CTRL_OFS, 32'h2);
    repeat (2000) @(posedge ref_clk);
    chk("conv before init", 32'h0, 32'(n_conv));
    $display("done: reset and idle");
    // Boundary cases: configuration rows and the init verdict
    for (int i = 0; i < 7; i++) begin
      wr(CFG_OFS, rows[i].cfg);
      wr(CTRL_OFS, 32'h1);
      rdc(STAT_OFS, 32'h3f, {27'h0, rows[i].ok, 4'h0}, "init");
    end
    // Only lane 1 lands: samples-per-buffer low byte changes, count stays
    avs_byteenable <= 4'h2;
    wr(CFG_OFS, 32'hffff03ff);
    avs_byteenable <= 4'hf;
    rdc(CFG_OFS, 32'h1ff7f, 32'h0302, "cfg lanes");
    wr(CFG_OFS, 32'h0202);
    $display("done: init rows");
    // Ping-pong run: two channels, raw samples, negative values
    wr(DEC_OFS, 32'h0);
    wr(COEF_OFS, 32'h80000000);
    wr(11'h100, {26'h0, tbl[0]});
    wr(11'h104, {26'h0, tbl[1]});
    restart();
    rdc(STAT_OFS, 32'h3f, 32'h30, "running");
    wait_rdy();
    chk("conv count", 32'h4, 32'(n_conv));
    rdc(STAT_OFS, 32'h3f, 32'h31, "ready one");
    wr(FETCH_OFS, 32'h1);
    rdc(STAT_OFS, 32'h7f, 32'h70, "after fetch");
    bufchk(0);
    wait_rdy();
    rdc(STAT_OFS, 32'h3, 32'h2, "ready two");
    wr(FETCH_OFS, 32'h2);
    bufchk(4);
    repeat (7400) @(posedge ref_clk);
    rdc(STAT_OFS, 32'h3, 32'h1, "overrun");
    wr(FETCH_OFS, 32'h2);
    rdc(STAT_OFS, 32'h3, 32'h1, "stale fetch");
    wr(CTRL_OFS, 32'h8);
    rdc(STAT_OFS, 32'h3, 32'h0, "clear");
    chk("min gap", 32'(CONV_DIV) + 1, 32'(min_gap));
    chk("max gap", 32'(CONV_DIV) + 1, 32'(max_gap));
    wr(CTRL_OFS, 32'h4);
    // A start pulse launched in the stop cycle may still be counted
    repeat (4) @(posedge ref_clk);
    n0 = n_conv;
    repeat (4000) @(posedge ref_clk);
    chk("after stop", 32'(n0), 32'(n_conv));
    $display("done: ping-pong");
    // Decimation with averaging, slow converter, channel 63
    base <= 16'h0100;
    slow <= 1'b1;
    wr(CFG_OFS, 32'h0201);
    wr(DEC_OFS, 32'h1);
    wr(COEF_OFS, 32'h40004000);
    wr(11'h100, 32'h3f);
    restart();
    wait_rdy();
    chk("dec count", 32'h4, 32'(n_conv));
    rdc(STAT_OFS, 32'h3, 32'h1, "first buffer");
    wr(FETCH_OFS, 32'h1);
    rdc(STAT_OFS, 32'h43, 32'h40, "dec fetch");
    y = 0;
    for (int k = 0; k < 4; k++) begin
      y = (y + 256 + k * 256 + 63) >>> 1;
      if (k % 2 == 1)
        rdc(11'(11'h400 + 2 * (k - 1)), 32'hffffffff, 32'(y), "avg");
    end
    wr(CTRL_OFS, 32'h4);
    $display("done: decimation");
    final_report();
  end
endmodule
